// ==== shared/sievt_params.svh ====
// Constants for the interrupt-vector and position-event command block
`ifndef SIEVT_PARAMS_SVH
`define SIEVT_PARAMS_SVH
`define SIEVT_OP_DEFINE_VECTOR_INSTR      8'h25
`define SIEVT_OP_RETH      8'h26
`define SIEVT_OP_UF_FIRST  8'h40
`define SIEVT_OP_UF_LAST   8'h47
`define SIEVT_OP_POSEVT    8'h8A
`define SIEVT_OP_IRQ_EN    8'h19
`define SIEVT_OP_IRQ_DIS   8'h1A
`define SIEVT_OP_MOVE      8'h04
`define SIEVT_ST_OK        8'h64
`define SIEVT_ST_POSREACH  8'h80
`define SIEVT_IRQ_GLOBAL   8'hFF
`define SIEVT_NUM_IRQ      16
`define SIEVT_PC_W         16
`endif

// ==== shared/sievt_pkg.sv ====
// Types for the interrupt-vector and position-event command block
package sievt_pkg;
  typedef struct packed {
    logic [7:0]  opcode;
    logic [7:0]  kind;
    logic [7:0]  bank;
    logic [31:0] value;
  } sievt_cmd_t;

  typedef struct packed {
    logic [7:0]  status;
    logic [7:0]  command;
    logic [31:0] value;
  } sievt_reply_t;

  typedef struct packed {
    logic [31:0] accu;
    logic [31:0] xreg;
    logic [7:0]  flags;
    logic [15:0] pc;
  } sievt_ctx_t;

  typedef enum logic [2:0] {
    SIEVT_RUN  = 3'b001,
    SIEVT_IRQ  = 3'b010,
    SIEVT_HALT = 3'b100
  } sievt_state_t;
endpackage : sievt_pkg

// ==== hw/sievt_core.sv ====
// Interrupt vector table, handler context save/restore, user functions and position-reached events
// What this block does
// RULE1: Opcode 37 stores value field as handler address for interrupt number in type.
// RULE2: Vector instruction takes interrupt number and label; motor/bank field ignored.
// RULE3: Redefining a vector overwrites the stored address; newest definition wins.
// RULE4: Program author uses vector definition only inside standalone programs.
// RULE5: Opcode 38 restores accumulator, X registers, flags and program counter.
// RULE6: Handlers end with return instruction; program flow never falls into them.
// RULE7: Vector and return in direct mode reply status 100, meaningless value.
// RULE8: Eight user-function opcodes reserved; direct mode replies status 100, extension value.
// RULE9: Opcode 138 replies at once and again when target position reached.
// RULE10: Host sends position-event request only in direct mode.
// RULE11: Value field is per-motor mask; single motor uses bit 0 only.
// RULE12: Type 0 reports only the next move-to-position, then disarms.
// RULE13: Type 1 reports every following move-to-position.
// RULE14: Delayed reply carries status 128, command 138, mask in low byte.
// RULE15: Enable-interrupt with number 255 globally enables interrupt processing.
// RULE16: Taking an interrupt saves context then jumps to stored entry address.
// RULE17: Return with no active handler leaves program state unchanged.
`timescale 1ns/1ns
`include "sievt_params.svh"
module sievt_core
  import sievt_pkg::*;
(
  input  wire logic                        MCLK,
  input  wire logic                        RST,
  input  wire logic                        CMD_VALID,
  input  wire sievt_cmd_t                  CMD,
  input  wire logic                        CMD_DIRECT,
  input  wire logic [`SIEVT_NUM_IRQ-1:0]   IRQ_REQ,
  input  wire logic [31:0]                 UF_RESULT,
  input  wire logic                        POS_REACHED,
  input  wire sievt_ctx_t                  CTX_NOW,
  output logic                             REPLY_VALID,
  output sievt_reply_t                     REPLY,
  output logic                             CTX_LOAD,
  output sievt_ctx_t                       CTX_OUT,
  output logic                             IN_HANDLER,
  output logic                             IRQ_GLOBAL_EN
);

  function automatic logic is_uf(input logic [7:0] op);
    is_uf = (op >= `SIEVT_OP_UF_FIRST) && (op <= `SIEVT_OP_UF_LAST);
  endfunction : is_uf

  logic [`SIEVT_PC_W-1:0] vec_addr_q [`SIEVT_NUM_IRQ];
  logic [`SIEVT_NUM_IRQ-1:0] vec_def_q;
  logic [`SIEVT_NUM_IRQ-1:0] irq_en_q;
  sievt_ctx_t     saved_q;
  sievt_state_t   state_q;
  logic           glob_q;
  logic           arm_q;
  logic           arm_all_q;
  logic           move_pend_q;
  logic [7:0]     mask_q;
  logic           rv_q;
  sievt_reply_t   rep_q;
  logic           ld_q;
  sievt_ctx_t     ctx_q;
  logic           in_hnd_q;
  logic           rch_q;

  wire logic [3:0] cmd_irq    = CMD.kind[3:0];
  wire logic       irq_in_rng = (CMD.kind < 8'(`SIEVT_NUM_IRQ));
  wire logic       is_define_vector_instr_op = CMD_VALID && CMD.opcode == `SIEVT_OP_DEFINE_VECTOR_INSTR;
  wire logic       do_define_vector_instr    = is_define_vector_instr_op && irq_in_rng;
  wire logic       do_reth    = CMD_VALID && CMD.opcode == `SIEVT_OP_RETH;
  wire logic       do_en      = CMD_VALID && CMD.opcode == `SIEVT_OP_IRQ_EN;
  wire logic       do_dis     = CMD_VALID && CMD.opcode == `SIEVT_OP_IRQ_DIS;
  wire logic       do_pos     = CMD_VALID && CMD.opcode == `SIEVT_OP_POSEVT;
  wire logic       do_move    = CMD_VALID && CMD.opcode == `SIEVT_OP_MOVE;
  wire logic       do_uf      = CMD_VALID && is_uf(CMD.opcode);
  wire logic [`SIEVT_NUM_IRQ-1:0] pend = IRQ_REQ & irq_en_q & vec_def_q;
  wire logic       take_irq   = glob_q && (state_q == SIEVT_RUN) && (|pend) && !CMD_VALID;
  wire logic       ret_ok     = do_reth && (state_q == SIEVT_IRQ);
  wire logic       pos_event  = move_pend_q && POS_REACHED;
  // Every direct request of this group is answered, even a vector whose number is ignored
  wire logic       imm_reply  = CMD_DIRECT && (is_define_vector_instr_op || do_reth || do_uf || do_pos);
  // A reached pulse that meets an immediate reply is parked and sent in the next free cycle
  wire logic       reach_due  = pos_event || rch_q;
  wire logic       send_reach = reach_due && !imm_reply;
  // Limitation: an arrival in a blocked cycle while another is already parked merges with it into one reply
  wire logic       rch_d      = pos_event ? !(send_reach && !rch_q) : (rch_q && !send_reach);

  logic [3:0] pick;
  always_comb begin
    pick = 4'h0;
    for (int i = `SIEVT_NUM_IRQ - 1; i >= 0; i--) begin
      if (pend[i]) pick = 4'(i);
    end
  end

  // Vector table; no reset on the array, the valid bits gate its use
  always_ff @(posedge MCLK) begin
    if (do_define_vector_instr) vec_addr_q[cmd_irq] <= CMD.value[`SIEVT_PC_W-1:0]; // [RULE1] [RULE2] [RULE3]
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      vec_def_q <= '0;
      irq_en_q  <= '0;
      glob_q    <= 1'b0;
    end else begin
      if (do_define_vector_instr) vec_def_q[cmd_irq] <= 1'b1; // [RULE1]
      if (do_en && CMD.kind == `SIEVT_IRQ_GLOBAL) glob_q <= 1'b1; // [RULE15]
      else if (do_dis && CMD.kind == `SIEVT_IRQ_GLOBAL) glob_q <= 1'b0;
      if (do_en && irq_in_rng) irq_en_q[cmd_irq] <= 1'b1;
      else if (do_dis && irq_in_rng) irq_en_q[cmd_irq] <= 1'b0;
    end
  end

  // Handler entry and return; no nesting, one saved context
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      state_q <= SIEVT_RUN;
      saved_q <= '0;
      ld_q    <= 1'b0;
      ctx_q   <= '0;
      in_hnd_q <= 1'b0;
    end else begin
      ld_q <= 1'b0;
      unique case (state_q)
        SIEVT_RUN: begin
          if (take_irq) begin
            saved_q  <= CTX_NOW; // [RULE16]
            ctx_q    <= '{CTX_NOW.accu, CTX_NOW.xreg, CTX_NOW.flags, vec_addr_q[pick]}; // [RULE16]
            ld_q     <= 1'b1;
            in_hnd_q <= 1'b1;
            state_q  <= SIEVT_IRQ;
          end
        end
        SIEVT_IRQ: begin
          if (ret_ok) begin
            ctx_q    <= saved_q; // [RULE5]
            ld_q     <= 1'b1;
            in_hnd_q <= 1'b0;
            state_q  <= SIEVT_RUN;
          end
        end
        SIEVT_HALT: state_q <= SIEVT_RUN;
        default: state_q <= SIEVT_RUN;
      endcase
    end
  end

  // Position-reached arming; a new request replaces the old setting
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      arm_q       <= 1'b0;
      arm_all_q   <= 1'b0;
      move_pend_q <= 1'b0;
      mask_q      <= 8'h00;
      rch_q       <= 1'b0;
    end else begin
      rch_q <= rch_d; // [RULE9]
      if (do_pos) begin
        arm_q     <= CMD.value[0]; // [RULE11]
        arm_all_q <= (CMD.kind == 8'h01); // [RULE13]
        mask_q    <= CMD.value[7:0];
      end else if (do_move && arm_q && !arm_all_q) begin
        arm_q <= 1'b0; // [RULE12]
      end
      // A new move wins over the arrival of the old one
      if (do_move && arm_q) move_pend_q <= 1'b1; // [RULE9]
      else if (pos_event) move_pend_q <= 1'b0;
    end
  end

  // Immediate replies take priority; a reached event is parked until a free cycle
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      rv_q  <= 1'b0;
      rep_q <= '0;
    end else begin
      rv_q <= 1'b0;
      if (imm_reply) begin
        rv_q          <= 1'b1;
        rep_q.status  <= `SIEVT_ST_OK; // [RULE7] [RULE8]
        rep_q.command <= CMD.opcode;
        rep_q.value   <= do_uf ? UF_RESULT : (do_pos ? {24'h000000, CMD.value[7:0]} : 32'h00000000);
      end else if (send_reach) begin
        rv_q          <= 1'b1;
        rep_q.status  <= `SIEVT_ST_POSREACH; // [RULE14]
        rep_q.command <= `SIEVT_OP_POSEVT;
        rep_q.value   <= {24'h000000, mask_q};
      end
    end
  end

  assign REPLY_VALID   = rv_q;
  assign REPLY         = rep_q;
  assign CTX_LOAD      = ld_q;
  assign CTX_OUT       = ctx_q;
  assign IN_HANDLER    = in_hnd_q;
  assign IRQ_GLOBAL_EN = glob_q;

  chk_reth_idle_noload: assert property (@(posedge MCLK) disable iff (RST) // [RULE17]
    (do_reth && state_q == SIEVT_RUN && !take_irq) |=> !CTX_LOAD)
    else $error("Return without handler reloaded context");
  chk_reth_restore_ctx: assert property (@(posedge MCLK) disable iff (RST) // [RULE5]
    ret_ok |=> (CTX_LOAD && CTX_OUT == $past(saved_q)))
    else $error("Return did not restore saved context");
  chk_irq_entry_pc: assert property (@(posedge MCLK) disable iff (RST) // [RULE16]
    take_irq |=> (CTX_LOAD && IN_HANDLER && CTX_OUT.accu == $past(CTX_NOW.accu)
                  && CTX_OUT.pc == $past(vec_addr_q[pick]) && saved_q == $past(CTX_NOW)))
    else $error("Interrupt entry did not save context");
  chk_global_enable: assert property (@(posedge MCLK) disable iff (RST) // [RULE15]
    (do_en && CMD.kind == 8'hFF) |=> IRQ_GLOBAL_EN)
    else $error("Global enable not set");
  chk_define_vector_instr_reply_ok: assert property (@(posedge MCLK) disable iff (RST) // [RULE7]
    (is_define_vector_instr_op && CMD_DIRECT) |=> (REPLY_VALID && REPLY.status == 8'h64))
    else $error("Vector reply status wrong");
  chk_uf_reply_val: assert property (@(posedge MCLK) disable iff (RST) // [RULE8]
    (do_uf && CMD_DIRECT) |=> (REPLY_VALID && REPLY.value == $past(UF_RESULT)))
    else $error("User function reply wrong");
  chk_pos_reply_fmt: assert property (@(posedge MCLK) disable iff (RST) // [RULE14]
    (REPLY_VALID && REPLY.status == 8'h80) |-> (REPLY.command == 8'h8A && REPLY.value[31:8] == 24'h0))
    else $error("Position reply format wrong");
  chk_oneshot_disarm: assert property (@(posedge MCLK) disable iff (RST) // [RULE12]
    (do_move && arm_q && !arm_all_q && !do_pos) |=> !arm_q)
    else $error("Type 0 did not disarm");
  chk_every_move_arm: assert property (@(posedge MCLK) disable iff (RST) // [RULE13]
    (do_move && arm_q && arm_all_q && !do_pos) |=> (arm_q && move_pend_q))
    else $error("Type 1 lost arming");
  chk_define_vector_instr_store: assert property (@(posedge MCLK) disable iff (RST) // [RULE3]
    do_define_vector_instr |=> (vec_addr_q[$past(cmd_irq)] == $past(CMD.value[15:0])))
    else $error("Vector not overwritten");
  chk_reach_parked: assert property (@(posedge MCLK) disable iff (RST) // [RULE9]
    (pos_event && imm_reply) |=> rch_q)
    else $error("Reached event lost behind an immediate reply");
  chk_reach_sent: assert property (@(posedge MCLK) disable iff (RST) // [RULE14]
    send_reach |=> (REPLY_VALID && REPLY.status == 8'h80 && REPLY.value[7:0] == $past(mask_q)))
    else $error("Reached reply not sent in a free cycle");
  chk_reth_idle_state: assert property (@(posedge MCLK) disable iff (RST) // [RULE17]
    (do_reth && !IN_HANDLER) |=> (!IN_HANDLER && $stable(CTX_OUT)))
    else $error("Return without handler changed program state");
endmodule : sievt_core

// ==== verification/sievt_motion_model.sv ====
// Motion side model: reports target reached a while after each move
`timescale 1ns/1ns
`include "sievt_params.svh"
module sievt_motion_model
  import sievt_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       cmd_valid,
  input  wire sievt_cmd_t cmd,
  input  wire logic [3:0] delay,
  output logic            reached
);
  logic [4:0] cnt_q;
  // One pulse per move, so a stale level cannot fake a second arrival
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q   <= 5'h00;
      reached <= 1'b0;
    end else begin
      reached <= (cnt_q == 5'h01);
      if (cmd_valid && cmd.opcode == `SIEVT_OP_MOVE) begin
        cnt_q <= {1'b0, delay} + 5'h01;
      end else if (cnt_q != 5'h00) begin
        cnt_q <= cnt_q - 5'h01;
      end
    end
  end
endmodule : sievt_motion_model

// ==== verification/sievt_core_tb_top.sv ====
// Self-checking bench for the vector, return, user-function and position-event block
`timescale 1ns/1ns
`include "sievt_params.svh"
module sievt_core_tb_top;
  import sievt_pkg::*;
  logic         MCLK = 1'b0, RST = 1'b1, CMD_VALID = 1'b0, CMD_DIRECT = 1'b0;
  logic         POS_REACHED, REPLY_VALID, CTX_LOAD, IN_HANDLER, IRQ_GLOBAL_EN;
  sievt_cmd_t   CMD = '0;
  sievt_ctx_t   CTX_NOW = '0, CTX_OUT, saved;
  sievt_reply_t REPLY;
  logic [15:0]  IRQ_REQ = 16'h0000;
  logic [31:0]  UF_RESULT = 32'h0, rnd = 32'h10F1E;
  logic [3:0]   dly = 4'h0;
  int           miscompares = 0, total_checks = 0;
  sievt_reply_t rq[$];
  sievt_ctx_t   cq[$];
  logic         rv[$], cf[$];
  always #10 MCLK = ~MCLK;
  sievt_core DUT (.MCLK(MCLK), .RST(RST), .CMD_VALID(CMD_VALID), .CMD(CMD), .CMD_DIRECT(CMD_DIRECT),
    .IRQ_REQ(IRQ_REQ), .UF_RESULT(UF_RESULT), .POS_REACHED(POS_REACHED), .CTX_NOW(CTX_NOW),
    .REPLY_VALID(REPLY_VALID), .REPLY(REPLY), .CTX_LOAD(CTX_LOAD), .CTX_OUT(CTX_OUT),
    .IN_HANDLER(IN_HANDLER), .IRQ_GLOBAL_EN(IRQ_GLOBAL_EN));
  sievt_motion_model PARTNER (.clk(MCLK), .rst(RST), .cmd_valid(CMD_VALID), .cmd(CMD), .delay(dly),
    .reached(POS_REACHED));
  function automatic void nxt();
    rnd = rnd ^ (rnd << 13);
    rnd = rnd ^ (rnd >> 17);
    rnd = rnd ^ (rnd << 5);
  endfunction : nxt
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : summarize
  task automatic bad(input string what, input logic [87:0] e, input logic [87:0] s);
    miscompares++;
    $display("BAD %s expected %h seen %h", what, e, s);
  endtask : bad
  task automatic cmp_reply(input sievt_reply_t e, input logic full, input sievt_reply_t s);
    total_checks++;
    if (!(s[47:32] === e[47:32] && (!full || s.value === e.value))) bad("reply", e, s);
  endtask : cmp_reply
  task automatic cmp_ctx(input sievt_ctx_t e, input logic full, input sievt_ctx_t s);
    total_checks++;
    if (!(full ? s === e : s.pc === e.pc)) bad("ctx_out", e, s);
  endtask : cmp_ctx
  task automatic cmp_bit(input string what, input logic e, input logic s);
    total_checks++;
    if (s !== e) bad(what, e, s);
  endtask : cmp_bit
  // Results appear registered, so the edge that shows them is where they are taken
  always @(posedge MCLK) begin
    if (REPLY_VALID === 1'b1) begin
      if (rq.size() == 0) bad("reply_extra", 88'h0, REPLY);
      else cmp_reply(rq.pop_front(), rv.pop_front(), REPLY);
    end
    if (CTX_LOAD === 1'b1) begin
      if (cq.size() == 0) bad("ctx_extra", 88'h0, CTX_OUT);
      else cmp_ctx(cq.pop_front(), cf.pop_front(), CTX_OUT);
    end
  end
  task automatic cmd(input logic [7:0] op, kind, input logic [31:0] val, input logic dir);
    @(posedge MCLK);
    nxt();
    CMD_VALID  <= 1'b1;
    CMD        <= '{op, kind, rnd[7:0], val};
    CMD_DIRECT <= dir;
    @(posedge MCLK);
    CMD_VALID  <= 1'b0;
  endtask : cmd
  task automatic expr(input logic [7:0] st, op, input logic [31:0] v, input logic full);
    rq.push_back('{st, op, v});
    rv.push_back(full);
  endtask : expr
  task automatic wait_hnd(input logic want);
    for (int i = 0; i < 40 && IN_HANDLER !== want; i++) @(posedge MCLK);
    total_checks++;
    if (IN_HANDLER !== want) begin
      bad("in_handler", want, IN_HANDLER);
      summarize();
    end
  endtask : wait_hnd
  initial begin
    repeat (6) @(posedge MCLK);
    RST <= 1'b0;
    expr(`SIEVT_ST_OK, `SIEVT_OP_DEFINE_VECTOR_INSTR, 32'h0, 1'b0);
    cmd(`SIEVT_OP_DEFINE_VECTOR_INSTR, 8'h03, 32'h0032, 1'b1);
    // Number out of range: table untouched, direct request still answered
    expr(`SIEVT_ST_OK, `SIEVT_OP_DEFINE_VECTOR_INSTR, 32'h0, 1'b0);
    cmd(`SIEVT_OP_DEFINE_VECTOR_INSTR, 8'hFF, 32'h0032, 1'b1);
    cmd(`SIEVT_OP_DEFINE_VECTOR_INSTR, 8'h03, 32'h0050, 1'b0);
    cmd(`SIEVT_OP_IRQ_EN, `SIEVT_IRQ_GLOBAL, 32'h0, 1'b0);
    cmd(`SIEVT_OP_IRQ_EN, 8'h03, 32'h0, 1'b0);
    cmp_bit("irq_global_en", 1'b1, IRQ_GLOBAL_EN);
    nxt();
    saved = '{rnd, ~rnd, rnd[7:0], rnd[15:0]};
    CTX_NOW <= saved;
    cq.push_back('{32'h0, 32'h0, 8'h00, 16'h0050});
    cf.push_back(1'b0);
    IRQ_REQ <= 16'h0208;
    wait_hnd(1'b1);
    IRQ_REQ <= 16'h0000;
    // Current context moves on inside the handler; the saved one must come back
    CTX_NOW <= ~saved;
    cq.push_back(saved);
    cf.push_back(1'b1);
    expr(`SIEVT_ST_OK, `SIEVT_OP_RETH, 32'h0, 1'b0);
    cmd(`SIEVT_OP_RETH, 8'hFF, 32'h0, 1'b1);
    wait_hnd(1'b0);
    expr(`SIEVT_ST_OK, `SIEVT_OP_RETH, 32'h0, 1'b0);
    cmd(`SIEVT_OP_RETH, 8'hFF, 32'h0, 1'b1);
    // Globally disabled: a defined, enabled source must not be taken
    cmd(`SIEVT_OP_IRQ_DIS, `SIEVT_IRQ_GLOBAL, 32'h0, 1'b0);
    IRQ_REQ <= 16'h0008;
    repeat (4) @(posedge MCLK);
    cmp_bit("irq_global_en", 1'b0, IRQ_GLOBAL_EN);
    cmp_bit("in_handler", 1'b0, IN_HANDLER);
    IRQ_REQ <= 16'h0000;
    for (int k = 0; k < 8; k++) begin
      nxt();
      UF_RESULT <= rnd;
      expr(`SIEVT_ST_OK, `SIEVT_OP_UF_FIRST + 8'(k), rnd, 1'b1);
      cmd(`SIEVT_OP_UF_FIRST + 8'(k), rnd[7:0], rnd, 1'b1);
    end
    for (int t = 0; t < 2; t++) begin
      expr(`SIEVT_ST_OK, `SIEVT_OP_POSEVT, 32'h1, 1'b1);
      cmd(`SIEVT_OP_POSEVT, 8'(t), 32'h1, 1'b1);
      for (int j = 0; j < 2; j++) begin
        nxt();
        dly <= rnd[3:0];
        if (t == 1 || j == 0) expr(`SIEVT_ST_POSREACH, `SIEVT_OP_POSEVT, 32'h1, 1'b1);
        cmd(`SIEVT_OP_MOVE, 8'h00, rnd, 1'b0);
        repeat (24) @(posedge MCLK);
      end
    end
    // Reached pulse lands on a direct user-function request; both replies must come, in order
    dly <= 4'h5;
    cmd(`SIEVT_OP_MOVE, 8'h00, 32'h0, 1'b0);
    UF_RESULT <= 32'h0000ABCD;
    expr(`SIEVT_ST_OK, `SIEVT_OP_UF_FIRST, 32'h0000ABCD, 1'b1);
    expr(`SIEVT_ST_POSREACH, `SIEVT_OP_POSEVT, 32'h1, 1'b1);
    repeat (5) @(posedge MCLK);
    cmd(`SIEVT_OP_UF_FIRST, 8'h00, 32'h0, 1'b1);
    repeat (24) @(posedge MCLK);
    repeat (10) @(posedge MCLK);
    total_checks++;
    if (rq.size() + cq.size() != 0) bad("pending", rq.size(), cq.size());
    summarize();
  end
  initial begin
    repeat (5000) @(posedge MCLK);
    bad("timeout", 88'h0, 88'h0);
    summarize();
  end
endmodule : sievt_core_tb_top
